// [src/activity_detector.sv]
`timescale 1ns/1ps
module activity_detector
  import motion_irq_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Sample stream
  input  wire logic       sample_tick,
  input  wire sample_t    sample,
  // Settings
  input  wire logic [7:0] threshold,
  input  wire logic [2:0] axis_enable,
  // Event pulse
  output logic            activity_q
);

  logic [15:0] axis [3];  // Axes as an array: z, y, x
  logic [2:0]  hit;       // Per-axis over-threshold
  logic        activity_d;

  assign axis[0] = sample.z;
  assign axis[1] = sample.y;
  assign axis[2] = sample.x;

  // Only participating axes may raise activity
  for (genvar i = 0; i < 3; i++) begin : g_axis
    assign hit[i] = axis_enable[i] && (axis_level(axis[i]) > threshold);
  end

  // Pulse once per qualifying sample
  always_comb begin
    activity_d = sample_tick && (|hit);
  end

  // Pulse register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) activity_q <= 1'b0;
    else activity_q <= activity_d;
  end

  // No activity without a participating axis
  property p_needs_axis;
    @(posedge clock) disable iff (!rstn)
    activity_q |-> $past(axis_enable) != 3'h0 && $past(sample_tick);
  endproperty
  a_needs_axis: assert property (p_needs_axis) else $error("activity without axis");

endmodule

// [src/motion_interrupt_logic.sv]
`timescale 1ns/1ps
module motion_interrupt_logic
  import motion_irq_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // New acceleration sample
  input  wire logic       sample_tick,
  input  wire sample_t    sample_in,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata_q,
  // Interrupt pins, push-pull
  output logic            irq_out_a_q,
  output logic            irq_out_b_q
);

  // Writable settings
  logic [7:0] tap_threshold_q, tap_threshold_d;
  logic [7:0] tap_duration_limit_q, tap_duration_limit_d;
  logic [7:0] tap_latency_time_q, tap_latency_time_d;
  logic [7:0] tap_window_time_q, tap_window_time_d;
  logic [7:0] activity_threshold_q, activity_threshold_d;
  logic [7:0] motion_axis_control_q, motion_axis_control_d;
  logic [7:0] irq_enable_mask_q, irq_enable_mask_d;
  logic [7:0] irq_pin_select_q, irq_pin_select_d;
  logic [7:0] output_format_control_q, output_format_control_d;

  // Latched event flags, same layout as the cause register
  logic [7:0] irq_cause_q, irq_cause_d;

  // Held sample as the host reads it
  sample_t    sample_q, sample_d;

  // Read data and pin levels
  logic [7:0] reg_rdata_d;
  logic       irq_out_a_d;
  logic       irq_out_b_d;

  // Detector outputs
  logic       single_hit;
  logic       double_hit;
  logic       activity_hit;
  tap_cfg_t   tap_cfg;

  // Access strobes with side effects
  logic       rd_cause;
  logic       rd_last_sample;
  logic [7:0] active_sources;

  assign tap_cfg = '{threshold: tap_threshold_q, duration: tap_duration_limit_q,
                     latency: tap_latency_time_q, window: tap_window_time_q};

  // Knock detection shares the held settings
  tap_detector u_tap (
    .clock        (clock),
    .rstn         (rstn),
    .sample_tick  (sample_tick),
    .sample       (sample_in),
    .cfg          (tap_cfg),
    .single_tap_q (single_hit),
    .double_tap_q (double_hit)
  );

  // Activity detection on participating axes
  activity_detector u_act (
    .clock       (clock),
    .rstn        (rstn),
    .sample_tick (sample_tick),
    .sample      (sample_in),
    .threshold   (activity_threshold_q),
    .axis_enable ({motion_axis_control_q[BIT_ACT_X],
                   motion_axis_control_q[BIT_ACT_Y],
                   motion_axis_control_q[BIT_ACT_Z]}),
    .activity_q  (activity_hit)
  );

  // Reads that clear flags
  assign rd_cause       = reg_rd && (reg_addr == ADDR_IRQ_CAUSE);
  assign rd_last_sample = reg_rd && (reg_addr == ADDR_Z_HIGH);

  // Settings writes; sample and cause registers ignore writes
  always_comb begin
    tap_threshold_d         = tap_threshold_q;
    tap_duration_limit_d    = tap_duration_limit_q;
    tap_latency_time_d      = tap_latency_time_q;
    tap_window_time_d       = tap_window_time_q;
    activity_threshold_d    = activity_threshold_q;
    motion_axis_control_d   = motion_axis_control_q;
    irq_enable_mask_d       = irq_enable_mask_q;
    irq_pin_select_d        = irq_pin_select_q;
    output_format_control_d = output_format_control_q;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_TAP_THRESHOLD:  tap_threshold_d = reg_wdata;
        ADDR_TAP_DURATION:   tap_duration_limit_d = reg_wdata;
        ADDR_TAP_LATENCY:    tap_latency_time_d = reg_wdata;
        ADDR_TAP_WINDOW:     tap_window_time_d = reg_wdata;
        ADDR_ACT_THRESHOLD:  activity_threshold_d = reg_wdata;
        ADDR_AXIS_CONTROL:   motion_axis_control_d = reg_wdata;
        ADDR_IRQ_ENABLE:     irq_enable_mask_d = reg_wdata;
        ADDR_IRQ_PIN_SELECT: irq_pin_select_d = reg_wdata;
        ADDR_FORMAT:         output_format_control_d = reg_wdata;
        default: ;
      endcase
    end
  end

  // Settings registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tap_threshold_q         <= REG_RESET;
      tap_duration_limit_q    <= REG_RESET;
      tap_latency_time_q      <= REG_RESET;
      tap_window_time_q       <= REG_RESET;
      activity_threshold_q    <= REG_RESET;
      motion_axis_control_q   <= REG_RESET;
      irq_enable_mask_q       <= REG_RESET;
      irq_pin_select_q        <= REG_RESET;
      output_format_control_q <= REG_RESET;
    end else begin
      tap_threshold_q         <= tap_threshold_d;
      tap_duration_limit_q    <= tap_duration_limit_d;
      tap_latency_time_q      <= tap_latency_time_d;
      tap_window_time_q       <= tap_window_time_d;
      activity_threshold_q    <= activity_threshold_d;
      motion_axis_control_q   <= motion_axis_control_d;
      irq_enable_mask_q       <= irq_enable_mask_d;
      irq_pin_select_q        <= irq_pin_select_d;
      output_format_control_q <= output_format_control_d;
    end
  end

  // Flags latch regardless of enable, so the cause register shows every
  // source; a new event in the clearing cycle wins over the clear
  always_comb begin
    sample_d    = sample_tick ? sample_in : sample_q;
    irq_cause_d = irq_cause_q;
    // Sample-ready stays until the last sample byte is read
    if (rd_last_sample) irq_cause_d[BIT_DATA_READY] = 1'b0;
    if (sample_tick) irq_cause_d[BIT_DATA_READY] = 1'b1;
    // Non-data flags clear on reading the cause register
    if (rd_cause) begin
      irq_cause_d[BIT_SINGLE_TAP] = 1'b0;
      irq_cause_d[BIT_DOUBLE_TAP] = 1'b0;
      irq_cause_d[BIT_ACTIVITY]   = 1'b0;
    end
    if (single_hit) irq_cause_d[BIT_SINGLE_TAP] = 1'b1;
    if (double_hit) irq_cause_d[BIT_DOUBLE_TAP] = 1'b1;
    if (activity_hit) irq_cause_d[BIT_ACTIVITY] = 1'b1;
  end

  // Flag and sample registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_cause_q <= REG_RESET;
      sample_q    <= '0;
    end else begin
      irq_cause_q <= irq_cause_d;
      sample_q    <= sample_d;
    end
  end

  // Read multiplexer; the cause read returns the value before clearing
  always_comb begin
    reg_rdata_d = reg_rdata_q;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_TAP_THRESHOLD:  reg_rdata_d = tap_threshold_q;
        ADDR_TAP_DURATION:   reg_rdata_d = tap_duration_limit_q;
        ADDR_TAP_LATENCY:    reg_rdata_d = tap_latency_time_q;
        ADDR_TAP_WINDOW:     reg_rdata_d = tap_window_time_q;
        ADDR_ACT_THRESHOLD:  reg_rdata_d = activity_threshold_q;
        ADDR_AXIS_CONTROL:   reg_rdata_d = motion_axis_control_q;
        ADDR_IRQ_ENABLE:     reg_rdata_d = irq_enable_mask_q;
        ADDR_IRQ_PIN_SELECT: reg_rdata_d = irq_pin_select_q;
        ADDR_IRQ_CAUSE:      reg_rdata_d = irq_cause_q;
        ADDR_FORMAT:         reg_rdata_d = output_format_control_q;
        ADDR_X_LOW:          reg_rdata_d = sample_q.x[7:0];
        ADDR_X_HIGH:         reg_rdata_d = sample_q.x[15:8];
        ADDR_Y_LOW:          reg_rdata_d = sample_q.y[7:0];
        ADDR_Y_HIGH:         reg_rdata_d = sample_q.y[15:8];
        ADDR_Z_LOW:          reg_rdata_d = sample_q.z[7:0];
        ADDR_Z_HIGH:         reg_rdata_d = sample_q.z[15:8];
        default:             reg_rdata_d = 8'h00;
      endcase
    end
  end

  // Sources that pass their enable; every one may run at once
  assign active_sources = irq_cause_q & irq_enable_mask_q;

  // Pin levels: pin-select 0 routes to a, 1 to b, polarity applied last
  always_comb begin
    irq_out_a_d = (|(active_sources & ~irq_pin_select_q))
                  ^ output_format_control_q[BIT_INVERT];
    irq_out_b_d = (|(active_sources & irq_pin_select_q))
                  ^ output_format_control_q[BIT_INVERT];
  end

  // Output registers; reset leaves both pins idle low (active high)
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
      irq_out_a_q <= 1'b0;
      irq_out_b_q <= 1'b0;
    end else begin
      reg_rdata_q <= reg_rdata_d;
      irq_out_a_q <= irq_out_a_d;
      irq_out_b_q <= irq_out_b_d;
    end
  end

  // Pin a follows mapped, enabled flags one cycle later
  property p_pin_a_level;
    @(posedge clock) disable iff (!rstn)
    ##1 irq_out_a_q == ($past(|(irq_cause_q & irq_enable_mask_q & ~irq_pin_select_q))
                        ^ $past(output_format_control_q[BIT_INVERT]));
  endproperty
  a_pin_a_level: assert property (p_pin_a_level) else $error("pin a level wrong");

  // Pin b follows mapped, enabled flags one cycle later
  property p_pin_b_level;
    @(posedge clock) disable iff (!rstn)
    ##1 irq_out_b_q == ($past(|(irq_cause_q & irq_enable_mask_q & irq_pin_select_q))
                        ^ $past(output_format_control_q[BIT_INVERT]));
  endproperty
  a_pin_b_level: assert property (p_pin_b_level) else $error("pin b level wrong");

  // With nothing enabled and normal polarity both pins stay low
  property p_disabled_quiet;
    @(posedge clock) disable iff (!rstn)
    (irq_enable_mask_q == 8'h00 && !output_format_control_q[BIT_INVERT])
      |=> (!irq_out_a_q && !irq_out_b_q);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("pin set while disabled");

  // Inverted polarity idles both pins high
  property p_inverted_idle;
    @(posedge clock) disable iff (!rstn)
    (output_format_control_q[BIT_INVERT] && active_sources == 8'h00)
      |=> (irq_out_a_q && irq_out_b_q);
  endproperty
  a_inverted_idle: assert property (p_inverted_idle) else $error("inverted idle wrong");

  // Reading the cause register clears non-data flags unless a new event lands
  property p_cause_clear;
    @(posedge clock) disable iff (!rstn)
    (rd_cause && !single_hit && !double_hit && !activity_hit)
      |=> irq_cause_q[BIT_SINGLE_TAP:BIT_ACTIVITY] == 3'h0;
  endproperty
  a_cause_clear: assert property (p_cause_clear) else $error("cause not cleared");

  // The single-knock flag holds until the cause register is read
  property p_flag_latched;
    @(posedge clock) disable iff (!rstn)
    (irq_cause_q[BIT_SINGLE_TAP] && !rd_cause) |=> irq_cause_q[BIT_SINGLE_TAP];
  endproperty
  a_flag_latched: assert property (p_flag_latched) else $error("flag lost");

  // A new sample raises sample-ready, visible on the next cycle
  property p_ready_set;
    @(posedge clock) disable iff (!rstn)
    sample_tick |=> irq_cause_q[BIT_DATA_READY];
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("sample ready not set");

  // Reading the last sample byte clears sample-ready if no new sample came
  property p_ready_clear;
    @(posedge clock) disable iff (!rstn)
    (rd_last_sample && !sample_tick) |=> !irq_cause_q[BIT_DATA_READY];
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("sample ready stuck");

endmodule

// [src/motion_irq_pkg.sv]
package motion_irq_pkg;

  // Register offsets on the register port
  localparam logic [7:0] ADDR_TAP_THRESHOLD  = 8'h1D;
  localparam logic [7:0] ADDR_TAP_DURATION   = 8'h21;
  localparam logic [7:0] ADDR_TAP_LATENCY    = 8'h22;
  localparam logic [7:0] ADDR_TAP_WINDOW     = 8'h23;
  localparam logic [7:0] ADDR_ACT_THRESHOLD  = 8'h24;
  localparam logic [7:0] ADDR_AXIS_CONTROL   = 8'h27;
  localparam logic [7:0] ADDR_IRQ_ENABLE     = 8'h2E;
  localparam logic [7:0] ADDR_IRQ_PIN_SELECT = 8'h2F;
  localparam logic [7:0] ADDR_IRQ_CAUSE      = 8'h30;
  localparam logic [7:0] ADDR_FORMAT         = 8'h31;
  localparam logic [7:0] ADDR_X_LOW          = 8'h32;
  localparam logic [7:0] ADDR_X_HIGH         = 8'h33;
  localparam logic [7:0] ADDR_Y_LOW          = 8'h34;
  localparam logic [7:0] ADDR_Y_HIGH         = 8'h35;
  localparam logic [7:0] ADDR_Z_LOW          = 8'h36;
  localparam logic [7:0] ADDR_Z_HIGH         = 8'h37;

  // Source bit positions in enable, pin-select and cause registers
  localparam int BIT_DATA_READY = 7;
  localparam int BIT_SINGLE_TAP = 6;
  localparam int BIT_DOUBLE_TAP = 5;
  localparam int BIT_ACTIVITY   = 4;

  // Polarity bit of the format register
  localparam int BIT_INVERT = 5;

  // Axis participation bits of the axis control register
  localparam int BIT_ACT_X = 6;
  localparam int BIT_ACT_Y = 5;
  localparam int BIT_ACT_Z = 4;

  // Reset value of every writable register
  localparam logic [7:0] REG_RESET = 8'h00;

  // Magnitude bits compared against 8-bit thresholds
  localparam int LEVEL_LSB = 5;
  localparam int LEVEL_MSB = 12;

  // One acceleration sample, three signed axes
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } sample_t;

  // Knock detector settings, all counts in sample periods
  typedef struct packed {
    logic [7:0] threshold;
    logic [7:0] duration;
    logic [7:0] latency;
    logic [7:0] window;
  } tap_cfg_t;

  // Saturated magnitude of one axis on the threshold scale
  function automatic logic [7:0] axis_level(input logic [15:0] s);
    logic [15:0] m;
    m = s[15] ? 16'(~s + 16'h0001) : s;
    if (m[15:LEVEL_MSB+1] != 3'h0) return 8'hFF;
    return m[LEVEL_MSB:LEVEL_LSB];
  endfunction

endpackage

// [src/tap_detector.sv]
`timescale 1ns/1ps
module tap_detector
  import motion_irq_pkg::*;
(
  // Clock and reset
  input  wire logic     clock,
  input  wire logic     rstn,
  // Sample stream
  input  wire logic     sample_tick,
  input  wire sample_t  sample,
  // Settings
  input  wire tap_cfg_t cfg,
  // Event pulses
  output logic          single_tap_q,
  output logic          double_tap_q
);

  // Gray-coded along idle, first, latency, window, second
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_FIRST  = 3'h1,
    ST_LATENT = 3'h3,
    ST_WINDOW = 3'h2,
    ST_SECOND = 3'h6,
    ST_REJECT = 3'h7
  } tap_state_t;

  tap_state_t state_q, state_d;  // Knock sequence state
  logic [7:0] cnt_q, cnt_d;      // Sample count in current phase
  logic       single_d;          // Next single pulse
  logic       double_d;          // Next double pulse
  logic       over;              // Any axis above knock threshold

  // Sequence decisions, taken only on a new sample
  always_comb begin
    over     = (axis_level(sample.x) > cfg.threshold) ||
               (axis_level(sample.y) > cfg.threshold) ||
               (axis_level(sample.z) > cfg.threshold);
    state_d  = state_q;
    cnt_d    = cnt_q;
    single_d = 1'b0;
    double_d = 1'b0;
    if (sample_tick) begin
      unique case (state_q)
        ST_IDLE: begin
          // Excursion starts
          if (over) begin
            state_d = ST_FIRST;
            cnt_d   = 8'h01;
          end
        end
        ST_FIRST: begin
          if (over) begin
            // Too long an excursion is no knock
            if (cnt_q >= cfg.duration) state_d = ST_REJECT;
            else cnt_d = 8'(cnt_q + 8'h01);
          end else if (cnt_q < cfg.duration) begin
            single_d = 1'b1;
            state_d  = ST_LATENT;
            cnt_d    = 8'h00;
          end else begin
            // Excursion reached the limit on its last sample: no knock
            state_d = ST_IDLE;
          end
        end
        ST_LATENT: begin
          // Excursions inside the latency are ignored
          if (cnt_q >= cfg.latency) begin
            state_d = ST_WINDOW;
            cnt_d   = 8'h00;
          end else begin
            cnt_d = 8'(cnt_q + 8'h01);
          end
        end
        ST_WINDOW: begin
          if (over) begin
            state_d = ST_SECOND;
            cnt_d   = 8'h01;
          end else if (cnt_q >= cfg.window) begin
            state_d = ST_IDLE;
          end else begin
            cnt_d = 8'(cnt_q + 8'h01);
          end
        end
        ST_SECOND: begin
          if (over) begin
            if (cnt_q >= cfg.duration) state_d = ST_REJECT;
            else cnt_d = 8'(cnt_q + 8'h01);
          end else begin
            // Second excursion must also stay below the limit
            double_d = (cnt_q < cfg.duration);
            state_d  = ST_IDLE;
          end
        end
        ST_REJECT: begin
          // Wait for the overlong excursion to end
          if (!over) state_d = ST_IDLE;
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q      <= ST_IDLE;
      cnt_q        <= 8'h00;
      single_tap_q <= 1'b0;
      double_tap_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      single_tap_q <= single_d;
      double_tap_q <= double_d;
    end
  end

  // A single knock only follows a short first excursion that just ended
  property p_single_short;
    @(posedge clock) disable iff (!rstn)
    single_tap_q |-> $past(state_q) == ST_FIRST && $past(cnt_q) < $past(cfg.duration);
  endproperty
  a_single_short: assert property (p_single_short) else $error("single knock too long");

  // A double knock ends a second excursion and returns to idle
  property p_double_ends;
    @(posedge clock) disable iff (!rstn)
    double_tap_q |-> $past(state_q) == ST_SECOND && state_q == ST_IDLE && !single_tap_q;
  endproperty
  a_double_ends: assert property (p_double_ends) else $error("double knock out of order");

endmodule

// [tb/motion_host.sv]
`timescale 1ns/1ps
// Host side of the register port; requests change 1 ns after a clock edge
module motion_host
  import motion_irq_pkg::*;
(
  // Clock
  input  wire logic       clock,
  // Register port
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata_q
);
  // Idle port at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // One-cycle write strobe; data inverted after so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clock) #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask

  // One-cycle read strobe; data taken 1 ns after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock) #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clock) #1;
    reg_rd   = 1'b0;
    d        = reg_rdata_q;
  endtask
endmodule

// [tb/motion_interrupt_logic_tb.sv]
`timescale 1ns/1ps
module motion_interrupt_logic_tb
  import motion_irq_pkg::*;
;
  logic       clock       = 1'b0; // 20 MHz system clock
  logic       rstn        = 1'b0; // Reset, active low
  logic       sample_tick = 1'b0; // New sample strobe
  sample_t    sample_in   = '0;   // Sample fed to the block
  logic [7:0] reg_addr;           // Register port from the host model
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_q;
  logic       irq_out_a_q;        // Interrupt pins
  logic       irq_out_b_q;
  int         fail_count      = 0;
  int         samples_checked = 0;
  logic [7:0] d;                  // Last value read back

  always #25 clock = ~clock;

  motion_interrupt_logic uut (.clock(clock), .rstn(rstn), .sample_tick(sample_tick),
    .sample_in(sample_in), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .irq_out_a_q(irq_out_a_q),
    .irq_out_b_q(irq_out_b_q));

  motion_host host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q));

  // Compare two bytes with case equality so unknowns fail
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One sample tick, then settle time for flag and pins
  task automatic tick(input logic [15:0] x, input logic [15:0] z);
    @(posedge clock) #1;
    sample_in   = '{x: x, y: 16'h0000, z: z};
    sample_tick = 1'b1;
    @(posedge clock) #1;
    sample_tick = 1'b0;
    sample_in   = ~sample_in;
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic results();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #(50 * 5000);
    fail_count++;
    results();
  end

  initial begin
    repeat (20) @(posedge clock);
    #1 rstn = 1'b1;
    chk({6'h00, irq_out_a_q, irq_out_b_q}, 8'h00);
    host.rd(ADDR_IRQ_CAUSE, d); chk(d, 8'h00);
    // Functions and mapping first, enables last
    host.wr(ADDR_IRQ_PIN_SELECT, 8'h50);
    host.wr(ADDR_ACT_THRESHOLD, 8'h10);
    host.wr(ADDR_AXIS_CONTROL, 8'h10);
    host.wr(ADDR_TAP_THRESHOLD, 8'h30);
    host.wr(ADDR_TAP_DURATION, 8'h03);
    host.wr(ADDR_TAP_LATENCY, 8'h00);
    host.wr(ADDR_TAP_WINDOW, 8'h05);
    host.rd(ADDR_IRQ_PIN_SELECT, d); chk(d, 8'h50);
    // Flag latches while disabled, pins stay quiet
    tick(16'h0000, 16'h0000);
    chk({6'h00, irq_out_a_q, irq_out_b_q}, 8'h00);
    host.rd(ADDR_IRQ_CAUSE, d); chk(d, 8'h80);
    for (int a = 8'h32; a <= 8'h37; a++) host.rd(8'(a), d);
    host.rd(ADDR_IRQ_CAUSE, d); chk(d, 8'h00);
    host.wr(ADDR_IRQ_ENABLE, 8'hD0);
    // Non-participating axis over threshold: sample-ready only, on pin a
    tick(16'h0400, 16'h0000);
    chk({6'h00, irq_out_a_q, irq_out_b_q}, 8'h02);
    host.rd(ADDR_IRQ_CAUSE, d); chk(d, 8'h80);
    // Participating axis: activity on pin b alongside sample-ready on a
    tick(16'h0000, 16'h0400);
    chk({6'h00, irq_out_a_q, irq_out_b_q}, 8'h03);
    host.rd(ADDR_IRQ_CAUSE, d); chk(d, 8'h90);
    host.wr(ADDR_IRQ_CAUSE, 8'hFF);
    host.rd(ADDR_IRQ_CAUSE, d); chk(d, 8'h80);
    repeat (2) @(posedge clock);
    #1 chk({6'h00, irq_out_a_q, irq_out_b_q}, 8'h02);
    // Inverted polarity on both pins
    host.wr(ADDR_FORMAT, 8'h20);
    repeat (2) @(posedge clock);
    #1 chk({6'h00, irq_out_a_q, irq_out_b_q}, 8'h01);
    host.rd(ADDR_Z_HIGH, d);
    repeat (2) @(posedge clock);
    #1 chk({6'h00, irq_out_a_q, irq_out_b_q}, 8'h03);
    host.wr(ADDR_FORMAT, 8'h00);
    repeat (2) @(posedge clock);
    #1 chk({6'h00, irq_out_a_q, irq_out_b_q}, 8'h00);
    // Two short excursions, second inside the window
    tick(16'h0000, 16'h0800);
    tick(16'h0000, 16'h0000);
    tick(16'h0000, 16'h0000);
    tick(16'h0000, 16'h0000);
    tick(16'h0000, 16'h0800);
    tick(16'h0000, 16'h0000);
    chk({7'h00, irq_out_b_q}, 8'h01);
    host.rd(ADDR_IRQ_CAUSE, d); chk(d, 8'hF0);
    host.rd(ADDR_IRQ_CAUSE, d); chk(d, 8'h80);
    // Reconfigure with the source disabled, then enable again
    host.wr(ADDR_IRQ_ENABLE, 8'hC0);
    host.wr(ADDR_ACT_THRESHOLD, 8'h7F);
    host.wr(ADDR_IRQ_ENABLE, 8'hD0);
    tick(16'h0000, 16'h0400);
    host.rd(ADDR_IRQ_CAUSE, d); chk(d, 8'h80);
    // Excursion as long as the limit is no knock, one sample shorter is
    repeat (3) tick(16'h0000, 16'h0800);
    tick(16'h0000, 16'h0000);
    host.rd(ADDR_IRQ_CAUSE, d); chk(d, 8'h80);
    repeat (2) tick(16'h0000, 16'h0800);
    tick(16'h0000, 16'h0000);
    host.rd(ADDR_IRQ_CAUSE, d); chk(d, 8'hC0);
    results();
  end
endmodule
